// *** shared/spv_pkg.sv ***
// Purpose: constants and types shared by the serial program/verify port
// Assumes: 14-bit program words, 8-bit data memory, 6-bit commands
// Notes:   opcodes are matched on their low bits as listed below
package spv_pkg;

    // ****************************************
    // widths and frame shape
    // ****************************************
    localparam int unsigned CMD_BITS     = 6;
    localparam int unsigned WORD_BITS    = 14;
    localparam int unsigned BYTE_BITS    = 8;
    localparam int unsigned ADDR_BITS    = 14;
    localparam int unsigned FRAME_CYCLES = 16;
    localparam logic [3:0]  CMD_LAST_CNT = 4'h5;
    localparam logic [3:0]  FRAME_LAST   = 4'hF;
    localparam logic [3:0]  PAYLOAD_LO   = 4'h1;
    localparam logic [3:0]  PAYLOAD_HI   = 4'hE;

    // ****************************************
    // address map
    // ****************************************
    localparam logic [13:0] ADDR_RESET   = 14'h0000;
    localparam logic [13:0] CFG_BASE     = 14'h2000;
    localparam logic [7:0]  CFG_HI_ZERO  = 8'h00;
    localparam int unsigned CFG_WORDS    = 32;
    localparam int unsigned CFG_WORD_IDX = 7;
    localparam int unsigned ID_WORDS     = 4;
    localparam int unsigned CP_BIT       = 7;
    localparam int unsigned CPD_BIT      = 8;
    localparam int unsigned DATA_WORDS   = 128;
    localparam logic [13:0] ERASED_WORD  = 14'h3FFF;
    localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

    // ****************************************
    // command codes (low bits, or all six bits for begin and end)
    // ****************************************
    localparam logic [3:0] OP_LOAD_CFG   = 4'h0;
    localparam logic [3:0] OP_LOAD_PROG  = 4'h2;
    localparam logic [3:0] OP_LOAD_DATA  = 4'h3;
    localparam logic [3:0] OP_READ_PROG  = 4'h4;
    localparam logic [3:0] OP_READ_DATA  = 4'h5;
    localparam logic [3:0] OP_INC_ADDR   = 4'h6;
    localparam logic [5:0] OP_BEGIN_INT  = 6'h08;
    localparam logic [5:0] OP_BEGIN_EXT  = 6'h18;
    localparam logic [5:0] OP_END_PROG   = 6'h0A;
    localparam logic [4:0] OP_ERASE_PROG = 5'h09;
    localparam logic [4:0] OP_ERASE_DATA = 5'h0B;

    typedef enum logic [0:0] {
        LINK_CMD   = 1'b0,
        LINK_FRAME = 1'b1
    } link_state_t;

    typedef enum logic [1:0] {
        LOAD_NONE = 2'b00,
        LOAD_PROG = 2'b01,
        LOAD_DATA = 2'b10
    } load_kind_t;

endpackage

// *** design/serial_program_verify_port.sv ***
// Purpose: device side of the two-wire serial program/verify port
// Assumes: mode select pin arrives as a logic level, high while at high voltage
// Notes:   serial logic runs on the programmer's clock; memories on CLOCK
`timescale 1ns/10ps

// Function
// - program mode holds other logic in reset and all I/O high impedance.
// - device reset clears the address counter to zero.
// - commands are six clocks, captured on falling edges, LSb first.
// - data frame is 16 clocks: start bit, payload LSb first, stop bit.
// - reads drive LSb from second rising edge, release after sixteenth rising edge.
// - loads capture payload LSb on second falling edge, then one per falling.
// - load codes decode on low four bits; data loads carry 8 bits.
// - read program, read data, increment decode on low four bits; increment has no frame.
// - begin internal, begin external, end, and both bulk erases decode as listed.
// - load configuration sets address to 0x2000 and takes a 14-bit word.
// - address top bit stays set in configuration space until mode exit.
// - increment wraps 0x1FFF to zero and 0x3FFF to 0x2000.
// - data loads store first 8 payload bits; all 16 clocks still needed.
// - data memory of 128 bytes uses low address bits only, wrapping.
// - protected program memory reads back all zeros.
// - data reads carry 8 data bits; protected data reads all zeros.
// - the four identification words read true even when protected.
// - configuration space implements up to 0x201F; words above 0x201F read zero.
// - auxiliary port pin stays tristated throughout program mode.
// - increment advances address by one; nothing decrements it.
// - external programming lasts until end command and erases nothing.
module serial_program_verify_port #(
    parameter int unsigned PROG_DEPTH = 1024
) (
    input  wire logic CLOCK,
    input  wire logic RST,
    input  wire logic MODE_SELECT_HV_PIN,
    input  wire logic SERIAL_CLOCK_PIN,
    input  wire logic SERIAL_DATA_PIN_IN,
    output logic      SERIAL_DATA_PIN_OUT,
    output logic      SERIAL_DATA_PIN_OE_N,
    output logic      OTHER_LOGIC_RESET,
    output logic      IO_HIZ,
    output logic      AUXILIARY_PORT_PIN_HIZ,
    output logic      PROG_BUSY
);

    localparam int unsigned PIDX = $clog2(PROG_DEPTH);
    localparam int unsigned SWEEP = (PROG_DEPTH > spv_pkg::DATA_WORDS) ?
                                    PROG_DEPTH : spv_pkg::DATA_WORDS;
    localparam int unsigned EIDX = $clog2(SWEEP);

    // ****************************************
    // mode entry, core side
    // ****************************************
    logic                         mode_sync1_reg;
    logic                         mode_sync2_reg;
    logic                         in_mode_reg;
    logic                         link_rst_reg;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            mode_sync1_reg <= 1'b0;
            mode_sync2_reg <= 1'b0;
            in_mode_reg    <= 1'b0;
            link_rst_reg   <= 1'b1;
        end else begin
            mode_sync1_reg <= MODE_SELECT_HV_PIN;
            mode_sync2_reg <= mode_sync1_reg;
            in_mode_reg    <= mode_sync2_reg;
            link_rst_reg   <= ~mode_sync2_reg;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            OTHER_LOGIC_RESET      <= 1'b1;
            IO_HIZ                 <= 1'b1;
            AUXILIARY_PORT_PIN_HIZ <= 1'b1;
        end else begin
            OTHER_LOGIC_RESET      <= mode_sync2_reg;
            IO_HIZ                 <= mode_sync2_reg;
            AUXILIARY_PORT_PIN_HIZ <= mode_sync2_reg;
        end
    end

    // ****************************************
    // link side: command and frame shifting
    // ****************************************
    spv_pkg::link_state_t         link_state_reg;
    logic [3:0]                   bit_cnt_reg;
    logic [spv_pkg::CMD_BITS-1:0] cmd_sh_reg;
    logic [spv_pkg::WORD_BITS-1:0] data_sh_reg;
    logic [spv_pkg::CMD_BITS-1:0] cmd_word_reg;
    logic [spv_pkg::WORD_BITS-1:0] frame_word_reg;
    logic                         cmd_tgl_reg;
    logic                         data_tgl_reg;
    logic                         frame_read_reg;
    logic [spv_pkg::CMD_BITS-1:0] cmd_next;
    logic [3:0]                   low_next;
    logic                         has_frame;
    logic                         is_read;

    always_comb begin
        cmd_next  = {SERIAL_DATA_PIN_IN, cmd_sh_reg[spv_pkg::CMD_BITS-1:1]};
        low_next  = cmd_next[3:0];
        is_read   = (low_next == spv_pkg::OP_READ_PROG) ||
                    (low_next == spv_pkg::OP_READ_DATA);
        has_frame = is_read ||
                    (low_next == spv_pkg::OP_LOAD_CFG)  ||
                    (low_next == spv_pkg::OP_LOAD_PROG) ||
                    (low_next == spv_pkg::OP_LOAD_DATA);
    end

    always_ff @(negedge SERIAL_CLOCK_PIN or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            link_state_reg <= spv_pkg::LINK_CMD;
            bit_cnt_reg    <= 4'h0;
            cmd_sh_reg     <= '0;
            data_sh_reg    <= '0;
            cmd_word_reg   <= '0;
            frame_word_reg <= '0;
            cmd_tgl_reg    <= 1'b0;
            data_tgl_reg   <= 1'b0;
            frame_read_reg <= 1'b0;
        end else begin
            unique case (link_state_reg)
                spv_pkg::LINK_CMD: begin
                    cmd_sh_reg <= cmd_next;
                    if (bit_cnt_reg == spv_pkg::CMD_LAST_CNT) begin
                        cmd_word_reg   <= cmd_next;
                        cmd_tgl_reg    <= ~cmd_tgl_reg;
                        frame_read_reg <= is_read;
                        bit_cnt_reg    <= 4'h0;
                        if (has_frame) begin
                            link_state_reg <= spv_pkg::LINK_FRAME;
                        end
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                spv_pkg::LINK_FRAME: begin
                    if (bit_cnt_reg >= spv_pkg::PAYLOAD_LO &&
                        bit_cnt_reg <= spv_pkg::PAYLOAD_HI) begin
                        data_sh_reg <= {SERIAL_DATA_PIN_IN,
                                        data_sh_reg[spv_pkg::WORD_BITS-1:1]};
                    end
                    if (bit_cnt_reg == spv_pkg::FRAME_LAST) begin
                        if (!frame_read_reg) begin
                            frame_word_reg <= data_sh_reg;
                            data_tgl_reg   <= ~data_tgl_reg;
                        end
                        bit_cnt_reg    <= 4'h0;
                        link_state_reg <= spv_pkg::LINK_CMD;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // link side: read data driver
    // ****************************************
    logic [spv_pkg::WORD_BITS-1:0] rd_word_reg;

    always_ff @(posedge SERIAL_CLOCK_PIN or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            SERIAL_DATA_PIN_OUT  <= 1'b0;
            SERIAL_DATA_PIN_OE_N <= 1'b1;
        end else if (link_state_reg == spv_pkg::LINK_FRAME && frame_read_reg &&
                     bit_cnt_reg >= spv_pkg::PAYLOAD_LO &&
                     bit_cnt_reg <= spv_pkg::PAYLOAD_HI) begin
            SERIAL_DATA_PIN_OUT  <= rd_word_reg[bit_cnt_reg - spv_pkg::PAYLOAD_LO];
            SERIAL_DATA_PIN_OE_N <= 1'b0;
        end else begin
            SERIAL_DATA_PIN_OUT  <= 1'b0;
            SERIAL_DATA_PIN_OE_N <= 1'b1;
        end
    end

    // ****************************************
    // event crossings into the core
    // ****************************************
    logic [2:0]                   cmd_sync_reg;
    logic [2:0]                   data_sync_reg;
    logic                         cmd_evt;
    logic                         data_evt;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cmd_sync_reg  <= 3'h0;
            data_sync_reg <= 3'h0;
        end else begin
            cmd_sync_reg  <= {cmd_sync_reg[1:0], cmd_tgl_reg};
            data_sync_reg <= {data_sync_reg[1:0], data_tgl_reg};
        end
    end

    assign cmd_evt  = in_mode_reg && (cmd_sync_reg[2] ^ cmd_sync_reg[1]);
    assign data_evt = in_mode_reg && (data_sync_reg[2] ^ data_sync_reg[1]);

    // ****************************************
    // core: memories and protection
    // ****************************************
    logic [spv_pkg::WORD_BITS-1:0] prog_mem [PROG_DEPTH];
    logic [spv_pkg::BYTE_BITS-1:0] data_mem [spv_pkg::DATA_WORDS];
    logic [spv_pkg::WORD_BITS-1:0] cfg_mem  [spv_pkg::CFG_WORDS];

    logic [spv_pkg::ADDR_BITS-1:0] addr_reg;
    logic [spv_pkg::WORD_BITS-1:0] load_word_reg;
    spv_pkg::load_kind_t          load_kind_reg;
    logic                         ext_prog_reg;
    logic                         erase_prog_reg;
    logic                         erase_data_reg;
    logic                         erase_id_reg;
    logic [EIDX-1:0]              erase_idx_reg;
    logic                         cp_on;
    logic                         cpd_on;
    logic                         in_cfg_impl;
    logic                         wr_go;
    logic [spv_pkg::CMD_BITS-1:0] cmd;

    assign cmd         = cmd_word_reg;
    assign cp_on       = ~cfg_mem[spv_pkg::CFG_WORD_IDX][spv_pkg::CP_BIT];
    assign cpd_on      = ~cfg_mem[spv_pkg::CFG_WORD_IDX][spv_pkg::CPD_BIT];
    assign in_cfg_impl = addr_reg[13] && (addr_reg[12:5] == spv_pkg::CFG_HI_ZERO);
    assign wr_go       = cmd_evt && (cmd == spv_pkg::OP_BEGIN_INT ||
                                     cmd == spv_pkg::OP_BEGIN_EXT);

    // ****************************************
    // core: address counter and command state
    // ****************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            addr_reg      <= spv_pkg::ADDR_RESET;
            load_kind_reg <= spv_pkg::LOAD_NONE;
        end else if (!in_mode_reg) begin
            addr_reg      <= spv_pkg::ADDR_RESET;
            load_kind_reg <= spv_pkg::LOAD_NONE;
        end else if (cmd_evt) begin
            unique case (cmd[3:0])
                spv_pkg::OP_LOAD_CFG: begin
                    addr_reg      <= spv_pkg::CFG_BASE;
                    load_kind_reg <= spv_pkg::LOAD_PROG;
                end
                spv_pkg::OP_LOAD_PROG: load_kind_reg <= spv_pkg::LOAD_PROG;
                spv_pkg::OP_LOAD_DATA: load_kind_reg <= spv_pkg::LOAD_DATA;
                spv_pkg::OP_INC_ADDR: begin
                    addr_reg <= {addr_reg[13], addr_reg[12:0] + 13'h0001};
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // core: load word capture
    // ****************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            load_word_reg <= '0;
        end else if (data_evt) begin
            load_word_reg <= frame_word_reg;
        end
    end

    // ****************************************
    // core: externally timed programming
    // ****************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ext_prog_reg <= 1'b0;
        end else if (!in_mode_reg) begin
            ext_prog_reg <= 1'b0;
        end else if (cmd_evt && cmd == spv_pkg::OP_BEGIN_EXT) begin
            ext_prog_reg <= 1'b1;
        end else if (cmd_evt && cmd == spv_pkg::OP_END_PROG) begin
            ext_prog_reg <= 1'b0;
        end
    end

    // ****************************************
    // core: read word for the next frame
    // ****************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rd_word_reg <= '0;
        end else if (cmd_evt && cmd[3:0] == spv_pkg::OP_READ_PROG) begin
            if (addr_reg[13]) begin
                rd_word_reg <= in_cfg_impl ? cfg_mem[addr_reg[4:0]] : '0;
            end else if (cp_on) begin
                rd_word_reg <= '0;
            end else begin
                rd_word_reg <= prog_mem[addr_reg[PIDX-1:0]];
            end
        end else if (cmd_evt && cmd[3:0] == spv_pkg::OP_READ_DATA) begin
            rd_word_reg <= cpd_on ? '0 :
                           {6'h00, data_mem[addr_reg[6:0]]};
        end
    end

    // ****************************************
    // core: bulk erase sweep
    // ****************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            erase_prog_reg <= 1'b0;
            erase_data_reg <= 1'b0;
            erase_id_reg   <= 1'b0;
            erase_idx_reg  <= '0;
        end else if (erase_prog_reg || erase_data_reg) begin
            erase_idx_reg <= erase_idx_reg + 1'b1;
            if (erase_idx_reg == EIDX'(SWEEP - 1)) begin
                erase_prog_reg <= 1'b0;
                erase_data_reg <= 1'b0;
                erase_id_reg   <= 1'b0;
            end
        end else if (cmd_evt && cmd[4:0] == spv_pkg::OP_ERASE_PROG) begin
            erase_prog_reg <= 1'b1;
            erase_data_reg <= cpd_on;
            erase_id_reg   <= addr_reg[13];
            erase_idx_reg  <= '0;
        end else if (cmd_evt && cmd[4:0] == spv_pkg::OP_ERASE_DATA && !cpd_on) begin
            erase_data_reg <= 1'b1;
            erase_idx_reg  <= '0;
        end
    end

    // ****************************************
    // core: busy flag
    // ****************************************
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PROG_BUSY <= 1'b0;
        end else begin
            PROG_BUSY <= ext_prog_reg || erase_prog_reg || erase_data_reg;
        end
    end

    // ****************************************
    // core: memory writes
    // ****************************************
    always_ff @(posedge CLOCK) begin
        if (erase_prog_reg && 32'(erase_idx_reg) < PROG_DEPTH) begin
            prog_mem[erase_idx_reg[PIDX-1:0]] <= spv_pkg::ERASED_WORD;
        end else if (wr_go && load_kind_reg == spv_pkg::LOAD_PROG &&
                     !addr_reg[13] && !cp_on) begin
            prog_mem[addr_reg[PIDX-1:0]] <= load_word_reg;
        end
        if (erase_data_reg && 32'(erase_idx_reg) < spv_pkg::DATA_WORDS) begin
            data_mem[erase_idx_reg[6:0]] <= spv_pkg::ERASED_BYTE;
        end else if (wr_go && load_kind_reg == spv_pkg::LOAD_DATA) begin
            data_mem[addr_reg[6:0]] <= load_word_reg[7:0];
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < spv_pkg::CFG_WORDS; i++) begin
                cfg_mem[i] <= spv_pkg::ERASED_WORD;
            end
        end else if (erase_id_reg && 32'(erase_idx_reg) < spv_pkg::ID_WORDS) begin
            cfg_mem[erase_idx_reg[4:0]] <= spv_pkg::ERASED_WORD;
        end else if (wr_go && load_kind_reg == spv_pkg::LOAD_PROG && in_cfg_impl) begin
            cfg_mem[addr_reg[4:0]] <= load_word_reg;
        end
    end

endmodule

// *** tb/spv_asserts.sv ***
// Purpose: port checker for the serial program/verify port
// Assumes: mode pin reaches the core through a two-flop synchroniser
// Notes:   bound from the testbench top file
`timescale 1ns/10ps
module spv_asserts #(
    parameter int unsigned PROG_DEPTH = 1024
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic MODE_SELECT_HV_PIN,
    input wire logic SERIAL_CLOCK_PIN,
    input wire logic SERIAL_DATA_PIN_IN,
    input wire logic SERIAL_DATA_PIN_OUT,
    input wire logic SERIAL_DATA_PIN_OE_N,
    input wire logic OTHER_LOGIC_RESET,
    input wire logic IO_HIZ,
    input wire logic AUXILIARY_PORT_PIN_HIZ,
    input wire logic PROG_BUSY
);
    // ****************************************
    // core clock domain
    // ****************************************
    chk_core_reset: assert property (
        @(posedge CLOCK) disable iff (RST)
        MODE_SELECT_HV_PIN [*6] |-> OTHER_LOGIC_RESET && IO_HIZ)
        else $error("core or io not held while in program mode");
    chk_aux_tristate: assert property (
        @(posedge CLOCK) disable iff (RST)
        MODE_SELECT_HV_PIN [*6] |-> AUXILIARY_PORT_PIN_HIZ)
        else $error("aux pin driven in program mode");
    chk_exit_release: assert property (
        @(posedge CLOCK) disable iff (RST)
        !MODE_SELECT_HV_PIN [*6] |-> !OTHER_LOGIC_RESET && !IO_HIZ)
        else $error("reset held outside program mode");
    chk_entry_delay: assert property (
        @(posedge CLOCK) disable iff (RST)
        $rose(OTHER_LOGIC_RESET) |-> MODE_SELECT_HV_PIN && $past(MODE_SELECT_HV_PIN, 2))
        else $error("core reset raised without mode pin");
    chk_idle_no_drive: assert property (
        @(posedge CLOCK) disable iff (RST)
        !MODE_SELECT_HV_PIN [*6] |-> SERIAL_DATA_PIN_OE_N)
        else $error("data pin driven outside program mode");
    chk_busy_in_mode: assert property (
        @(posedge CLOCK) disable iff (RST)
        $rose(PROG_BUSY) |-> MODE_SELECT_HV_PIN && OTHER_LOGIC_RESET)
        else $error("busy raised outside program mode");
    chk_drive_on_rise: assert property (
        @(posedge CLOCK) disable iff (RST)
        MODE_SELECT_HV_PIN [*6] ##0 (!SERIAL_CLOCK_PIN && !$past(SERIAL_CLOCK_PIN))
        |-> $stable(SERIAL_DATA_PIN_OUT) && $stable(SERIAL_DATA_PIN_OE_N))
        else $error("data pin changed without a rising serial clock");
    // ****************************************
    // link clock domain check, then cover points
    // ****************************************
    chk_read_window: assert property (
        @(negedge SERIAL_CLOCK_PIN) disable iff (RST)
        $fell(SERIAL_DATA_PIN_OE_N) |-> ##13 !SERIAL_DATA_PIN_OE_N ##1 SERIAL_DATA_PIN_OE_N)
        else $error("read drive window not fourteen cycles");
    cov_read: cover property (@(negedge SERIAL_CLOCK_PIN) $fell(SERIAL_DATA_PIN_OE_N));
    cov_busy: cover property (@(posedge CLOCK) $rose(PROG_BUSY));
    cov_entry: cover property (@(posedge CLOCK) $rose(OTHER_LOGIC_RESET));
endmodule

// *** tb/spv_programmer.sv ***
// Purpose: behavioural external programmer on the two-wire link
// Assumes: link clock 64 ns, idle low between frames
// Notes:   released data line toggles so a missing drive is seen
`timescale 1ns/10ps
module spv_programmer (
    output logic      SERIAL_CLOCK,
    output logic      DATA_DRIVE,
    input  wire logic DATA_LEVEL
);
    initial begin
        SERIAL_CLOCK = 1'b0;
        DATA_DRIVE   = 1'b0;
    end
    // one cycle: set at rise, device takes at fall
    task automatic cycle(input logic b, output logic r);
        SERIAL_CLOCK = 1'b1;
        DATA_DRIVE   = b;
        #32;
        r = DATA_LEVEL;
        SERIAL_CLOCK = 1'b0;
        #32;
    endtask
    task automatic command(input logic [5:0] code);
        logic r;
        for (int i = 0; i < 6; i++) begin
            cycle(code[i], r);
        end
        DATA_DRIVE = 1'b0;
        #1000;
    endtask
    task automatic frame(input logic rd, input logic [13:0] w, output logic [13:0] q);
        logic        r;
        logic [15:0] bits;
        bits = {1'b0, w, 1'b0};
        q = 14'h0000;
        for (int i = 0; i < 16; i++) begin
            cycle(rd ? ~DATA_DRIVE : bits[i], r);
            if (i >= 1 && i <= 14) begin
                q[i-1] = r;
            end
        end
        DATA_DRIVE = 1'b0;
        #1000;
    endtask
endmodule

// *** tb/tb.sv ***
// Purpose: self-checking bench for the serial program/verify port
// Assumes: small program depth, config word starts unprotected
// Notes:   scenarios run in order; program protection is set partway through t_cfg, data protection last
`timescale 1ns/10ps
bind serial_program_verify_port spv_asserts #(.PROG_DEPTH(PROG_DEPTH)) i_spv_asserts (
    .CLOCK(CLOCK), .RST(RST), .MODE_SELECT_HV_PIN(MODE_SELECT_HV_PIN),
    .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SERIAL_DATA_PIN_IN(SERIAL_DATA_PIN_IN),
    .SERIAL_DATA_PIN_OUT(SERIAL_DATA_PIN_OUT), .SERIAL_DATA_PIN_OE_N(SERIAL_DATA_PIN_OE_N),
    .OTHER_LOGIC_RESET(OTHER_LOGIC_RESET), .IO_HIZ(IO_HIZ),
    .AUXILIARY_PORT_PIN_HIZ(AUXILIARY_PORT_PIN_HIZ), .PROG_BUSY(PROG_BUSY));
module tb;
    localparam int LIMIT = 60000;
    logic clock, rst, mode_sel, sclk, prog_d, pin_in, d_out, oe_n, core_rst, io_hiz, aux_hiz, busy;
    int   errors, comparisons, cycles;
    localparam logic [5:0] RD_P = {2'b10, spv_pkg::OP_READ_PROG};
    localparam logic [5:0] RD_D = {2'b11, spv_pkg::OP_READ_DATA};
    localparam logic [5:0] INC  = {2'b01, spv_pkg::OP_INC_ADDR};
    assign pin_in = oe_n ? prog_d : d_out;
    serial_program_verify_port #(.PROG_DEPTH(64)) i_serial_program_verify_port (
        .CLOCK(clock), .RST(rst), .MODE_SELECT_HV_PIN(mode_sel), .SERIAL_CLOCK_PIN(sclk),
        .SERIAL_DATA_PIN_IN(pin_in), .SERIAL_DATA_PIN_OUT(d_out), .SERIAL_DATA_PIN_OE_N(oe_n),
        .OTHER_LOGIC_RESET(core_rst), .IO_HIZ(io_hiz), .AUXILIARY_PORT_PIN_HIZ(aux_hiz),
        .PROG_BUSY(busy));
    spv_programmer i_spv_programmer (.SERIAL_CLOCK(sclk), .DATA_DRIVE(prog_d), .DATA_LEVEL(pin_in));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic stop_test();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            stop_test();
        end
    end
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [5:0] c);
        i_spv_programmer.command(c);
    endtask
    task automatic load(input logic [5:0] c, input logic [13:0] w);
        logic [13:0] q;
        cmd(c);
        i_spv_programmer.frame(1'b0, w, q);
    endtask
    task automatic read_chk(input logic [5:0] c, input logic [13:0] exp);
        logic [13:0] q;
        cmd(c);
        i_spv_programmer.frame(1'b1, 14'h0000, q);
        check(q, exp);
    endtask
    task automatic enter_mode();
        @(posedge clock) #1 mode_sel = 1'b0;
        repeat (20) @(posedge clock);
        #1 mode_sel = 1'b1;
        repeat (12) @(posedge clock);
        #13;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_entry();
        enter_mode();
        check({10'h000, core_rst, io_hiz, aux_hiz, oe_n}, 14'h000F);
        $display("test entry done");
    endtask
    task automatic t_prog();
        enter_mode();
        load({2'b11, spv_pkg::OP_LOAD_PROG}, 14'h2A5C);
        cmd(spv_pkg::OP_BEGIN_INT);
        read_chk(RD_P, 14'h2A5C);
        cmd(6'h07);
        read_chk(RD_P, 14'h2A5C);
        cmd(INC);
        load({2'b00, spv_pkg::OP_LOAD_PROG}, 14'h1533);
        cmd(spv_pkg::OP_BEGIN_EXT);
        check({13'h0000, busy}, 14'h0001);
        cmd(spv_pkg::OP_END_PROG);
        check({13'h0000, busy}, 14'h0000);
        read_chk(RD_P, 14'h1533);
        enter_mode();
        read_chk(RD_P, 14'h2A5C);
        $display("test program memory done");
    endtask
    task automatic t_data();
        enter_mode();
        cmd({2'b00, spv_pkg::OP_INC_ADDR});
        load({2'b01, spv_pkg::OP_LOAD_DATA}, 14'h3F5A);
        cmd(spv_pkg::OP_BEGIN_INT);
        read_chk(RD_D, 14'h005A);
        $display("test data memory done");
    endtask
    task automatic t_cfg();
        enter_mode();
        load({2'b00, spv_pkg::OP_LOAD_CFG}, 14'h0055);
        cmd(spv_pkg::OP_BEGIN_INT);
        read_chk(RD_P, 14'h0055);
        repeat (7) cmd(INC);
        load({2'b00, spv_pkg::OP_LOAD_PROG}, 14'h3F7F);
        cmd(spv_pkg::OP_BEGIN_INT);
        read_chk(RD_P, 14'h3F7F);
        enter_mode();
        read_chk(RD_P, 14'h0000);
        load({2'b11, spv_pkg::OP_LOAD_CFG}, 14'h0000);
        read_chk(RD_P, 14'h0055);
        cmd(INC);
        load({2'b10, spv_pkg::OP_LOAD_PROG}, 14'h0011);
        cmd(spv_pkg::OP_BEGIN_INT);
        read_chk(RD_P, 14'h0011);
        read_chk(RD_D, 14'h005A);
        cmd({1'b0, spv_pkg::OP_ERASE_DATA});
        read_chk(RD_D, 14'h00FF);
        cmd({1'b1, spv_pkg::OP_ERASE_PROG});
        read_chk(RD_P, 14'h3FFF);
        repeat (6) cmd(INC);
        load({2'b00, spv_pkg::OP_LOAD_PROG}, 14'h3E7F);
        cmd(spv_pkg::OP_BEGIN_INT);
        read_chk(RD_D, 14'h0000);
        $display("test configuration done");
    endtask
    initial begin
        errors = 0;
        comparisons = 0;
        cycles = 0;
        rst = 1'b1;
        mode_sel = 1'b0;
        repeat (5) @(posedge clock);
        #1 rst = 1'b0;
        t_entry();
        t_prog();
        t_data();
        t_cfg();
        stop_test();
    end
endmodule
